// ===== hdl/cgup_consts.vh
/*
  cgup_consts.vh: register offsets, field positions, reset values, source
  codes and timing counts for the clock generation block.
  assumes: included by the design files of the block, definitions only.
*/
`ifndef CGUP_CONSTS_VH
`define CGUP_CONSTS_VH

// register byte offsets on the apb bus
`define CGUP_ADDR_CTRL 8'h00
`define CGUP_ADDR_STATUS 8'h04
`define CGUP_ADDR_OUTSEL 8'h08
`define CGUP_ADDR_EVEN 8'h0C

// control register fields
`define CGUP_CTRL_PD 0
`define CGUP_CTRL_BYP 1
`define CGUP_CTRL_PSEL 2
`define CGUP_CTRL_P23 4
`define CGUP_CTRL_INSEL 5
`define CGUP_CTRL_FBM 8
`define CGUP_CTRL_RST 32'h00000401

// event enable fields: rise enables low, fall enables high
`define CGUP_EVEN_UP 0
`define CGUP_EVEN_DOWN 16
`define CGUP_EVEN_RST 32'h00000000

// source codes
`define CGUP_SRC_RING 3'h0
`define CGUP_SRC_XTAL 3'h1
`define CGUP_SRC_HOA 3'h2
`define CGUP_SRC_HOB 3'h3
`define CGUP_SRC_PLL 3'h4
`define CGUP_SRC_LAST 3'h6

// timing: slow control clock period and pclk period in ns
`define CGUP_SLOW_NS 2500
`define CGUP_PCLK_NS 8
`define CGUP_ACT_LIMIT 6'h20
`define CGUP_HOLD_CYC 3'h2
`define CGUP_LOCK_CONFIRM 3'h4
`define CGUP_LOCK_TOL 16'h0001

`endif

// ===== hdl/cgup_actdet.v
/*
  cgup_actdet.v: activity detector for one clock source. syncs the source,
  watches its rising edges against slow control clock ticks, reports
  activity, stuck-high level and activity changes.
  assumes: slow_tick is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/100ps
`include "cgup_consts.vh"

module cgup_actdet (
  input wire pclk,
  input wire presetn,
  input wire src_clock,
  input wire slow_tick,
  output wire sync_level,
  output wire rise_seen,
  output reg active,
  output wire stuck_high,
  output reg went_active,
  output reg went_inactive
);
  reg s1;
  reg s2;
  reg s3;
  reg [5:0] idle_cnt;
  reg [5:0] high_cnt;

  assign sync_level = s2;
  assign rise_seen = s2 & ~s3;
  assign stuck_high = (high_cnt == `CGUP_ACT_LIMIT);

  // two-flop synchroniser and edge history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= src_clock;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // activity: starts absent, edge restarts the slow count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      idle_cnt <= 6'h00;
      went_active <= 1'b0;
      went_inactive <= 1'b0;
    end else begin
      went_active <= 1'b0;
      went_inactive <= 1'b0;
      if (rise_seen) begin
        idle_cnt <= 6'h00;
        active <= 1'b1;
        went_active <= ~active;
      end else if (slow_tick && active) begin
        if (idle_cnt == `CGUP_ACT_LIMIT - 6'h01) begin
          active <= 1'b0;
          idle_cnt <= 6'h00;
          went_inactive <= 1'b1;
        end else begin
          idle_cnt <= idle_cnt + 6'h01;
        end
      end
    end
  end

  // stuck-high count of slow ticks while the level stays high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt <= 6'h00;
    end else if (!s2) begin
      high_cnt <= 6'h00;
    end else if (slow_tick && !stuck_high) begin
      high_cnt <= high_cnt + 6'h01;
    end
  end
endmodule

// ===== hdl/cgup_clock_gen.v
/*
  cgup_clock_gen.v: clock generation unit top. activity detection on all
  sources, pll with post divider, bypass, lock detector and extra phases,
  glitch-free output generators, apb register slave.
  assumes: apb master on pclk; source clocks are asynchronous pins or
  internal pll outputs; handoff clocks come from the main generator.
*/
`timescale 1ns/100ps
`include "cgup_consts.vh"

module cgup_clock_gen #(
  parameter NOUT = 2
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ring_oscillator,
  input wire crystal_input,
  output reg crystal_output,
  input wire handoff_base_clock_a,
  input wire handoff_base_clock_b,
  output wire [NOUT-1:0] base_clock_out,
  output reg pll_main_output,
  output reg pll_phase2_output,
  output reg pll_phase3_output,
  output reg pll_lock,
  output reg [6:0] src_activated,
  output reg [6:0] src_deactivated
);
  localparam NSRC = 7;
  localparam SLOW_DIV = `CGUP_SLOW_NS / `CGUP_PCLK_NS;
  localparam ST_RUN = 2'h0;
  localparam ST_DRAIN = 2'h1;
  localparam ST_HOLD = 2'h2;

  // control and configuration state
  reg pll_power_down;
  reg bypass;
  reg [1:0] post_sel;
  reg extra_phase_enable;
  reg [2:0] pll_in_cfg;
  reg [2:0] pll_in_cur;
  reg [7:0] fb_div;
  reg [3*NOUT-1:0] out_sel;
  reg [6:0] en_up;
  reg [6:0] en_down;
  reg [9:0] slow_cnt;
  reg slow_tick;
  reg [5:0] valid_cnt;
  reg presence_valid;
  reg controlled_oscillator;
  reg [5:0] mcnt;
  reg [5:0] p2cnt;
  reg [5:0] p3cnt;
  reg main_prev;
  reg [7:0] fb_cnt;
  reg fb_edge;
  reg [15:0] ref_per;
  reg [15:0] ref_meas;
  reg [15:0] fb_per;
  reg [2:0] lock_cnt;

  wire [NSRC-1:0] lvl;
  wire [NSRC-1:0] rise;
  wire [NSRC-1:0] source_presence_status;
  wire [NSRC-1:0] stuck;
  wire [NSRC-1:0] up;
  wire [NSRC-1:0] down;
  wire [NSRC-1:0] src_in;
  wire apb_setup;
  wire apb_write;
  wire [5:0] half;
  wire [5:0] full;
  wire [5:0] off1;
  wire [5:0] off2;
  wire [15:0] dlt;
  wire main_rise;

  assign src_in = {pll_phase3_output, pll_phase2_output, pll_main_output,
                   handoff_base_clock_b, handoff_base_clock_a,
                   crystal_input, ring_oscillator};
  assign apb_setup = psel & ~penable & ~pready;
  assign apb_write = psel & penable & pready & pwrite;

  // wraps a counter sum into one period
  function [5:0] wrap6;
    input [6:0] v;
    input [5:0] f;
    begin
      if (v >= {1'b0, f})
        wrap6 = v[5:0] - f;
      else
        wrap6 = v[5:0];
    end
  endfunction

  // slow control clock tick, derived from pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= 10'h000;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (slow_cnt == SLOW_DIV[9:0] - 10'h001);
      if (slow_cnt == SLOW_DIV[9:0] - 10'h001)
        slow_cnt <= 10'h000;
      else
        slow_cnt <= slow_cnt + 10'h001;
    end
  end

  // presence status becomes valid after 32 slow ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_cnt <= 6'h00;
      presence_valid <= 1'b0;
    end else if (slow_tick && !presence_valid) begin
      valid_cnt <= valid_cnt + 6'h01;
      presence_valid <= (valid_cnt == `CGUP_ACT_LIMIT - 6'h01);
    end
  end

  // one activity detector per source
  genvar i;
  generate
    for (i = 0; i < NSRC; i = i + 1) begin : det
      cgup_actdet u_det (
        .pclk(pclk),
        .presetn(presetn),
        .src_clock(src_in[i]),
        .slow_tick(slow_tick),
        .sync_level(lvl[i]),
        .rise_seen(rise[i]),
        .active(source_presence_status[i]),
        .stuck_high(stuck[i]),
        .went_active(up[i]),
        .went_inactive(down[i])
      );
    end
  endgenerate

  // activation and deactivation events, gated by enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_activated <= 7'h00;
      src_deactivated <= 7'h00;
    end else begin
      src_activated <= up & en_up;
      src_deactivated <= down & en_down;
    end
  end

  // apb writes; select writes only land on present, valid sources
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_power_down <= 1'b1;
      bypass <= 1'b0;
      post_sel <= 2'h0;
      extra_phase_enable <= 1'b0;
      pll_in_cfg <= `CGUP_SRC_RING;
      fb_div <= 8'h04;
      out_sel <= {(3*NOUT){1'b0}};
      en_up <= 7'h00;
      en_down <= 7'h00;
    end else if (apb_write) begin
      if (paddr == `CGUP_ADDR_CTRL) begin
        pll_power_down <= pwdata[`CGUP_CTRL_PD];
        bypass <= pwdata[`CGUP_CTRL_BYP];
        post_sel <= pwdata[`CGUP_CTRL_PSEL +: 2];
        extra_phase_enable <= pwdata[`CGUP_CTRL_P23];
        fb_div <= pwdata[`CGUP_CTRL_FBM +: 8];
        if (pwdata[`CGUP_CTRL_INSEL +: 3] <= `CGUP_SRC_HOB &&
            source_presence_status[pwdata[`CGUP_CTRL_INSEL +: 3]])
          pll_in_cfg <= pwdata[`CGUP_CTRL_INSEL +: 3];
      end
      if (paddr == `CGUP_ADDR_OUTSEL) begin
        for (k = 0; k < NOUT; k = k + 1) begin
          if (pwdata[3*k +: 3] <= `CGUP_SRC_LAST &&
              source_presence_status[pwdata[3*k +: 3]])
            out_sel[3*k +: 3] <= pwdata[3*k +: 3];
        end
      end
      if (paddr == `CGUP_ADDR_EVEN) begin
        en_up <= pwdata[`CGUP_EVEN_UP +: 7];
        en_down <= pwdata[`CGUP_EVEN_DOWN +: 7];
      end
    end
  end

  // apb answer: one access cycle, read data and error registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup) begin
        case (paddr)
          `CGUP_ADDR_CTRL:
            prdata <= {16'h0000, fb_div, pll_in_cfg, extra_phase_enable,
                       post_sel, bypass, pll_power_down};
          `CGUP_ADDR_STATUS:
            prdata <= {17'h00000, source_presence_status, 6'h00,
                       presence_valid, pll_lock};
          `CGUP_ADDR_OUTSEL:
            prdata <= {{(32-3*NOUT){1'b0}}, out_sel};
          `CGUP_ADDR_EVEN:
            prdata <= {9'h000, en_down, 9'h000, en_up};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // crystal driver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      crystal_output <= 1'b0;
    else
      crystal_output <= ~lvl[`CGUP_SRC_XTAL];
  end

  // pll input switch: change only while the old reference is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pll_in_cur <= `CGUP_SRC_RING;
    else if (pll_in_cur != pll_in_cfg && !lvl[pll_in_cur])
      pll_in_cur <= pll_in_cfg;
  end

  // divider periods in pclk cycles; bypass makes period two
  assign half = bypass ? 6'h01 : (6'h02 << post_sel);
  assign full = {half[4:0], 1'b0};
  assign off1 = full / 6'h03;
  assign off2 = {off1[4:0], 1'b0};

  // oscillator and post dividers; power-down holds all in reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controlled_oscillator <= 1'b0;
      mcnt <= 6'h00;
      p2cnt <= 6'h00;
      p3cnt <= 6'h00;
      pll_main_output <= 1'b0;
      pll_phase2_output <= 1'b0;
      pll_phase3_output <= 1'b0;
    end else if (pll_power_down) begin
      controlled_oscillator <= 1'b0;
      mcnt <= 6'h00;
      p2cnt <= 6'h00;
      p3cnt <= 6'h00;
      pll_main_output <= 1'b0;
      pll_phase2_output <= 1'b0;
      pll_phase3_output <= 1'b0;
    end else begin
      controlled_oscillator <= ~controlled_oscillator;
      mcnt <= (mcnt >= full - 6'h01) ? 6'h00 : mcnt + 6'h01;
      pll_main_output <= bypass ? controlled_oscillator : (mcnt < half);
      if (!extra_phase_enable) begin
        p2cnt <= 6'h00;
        p3cnt <= 6'h00;
      end else if (pll_lock) begin
        p2cnt <= wrap6({1'b0, mcnt} + {1'b0, off2} + 7'h01, full);
        p3cnt <= wrap6({1'b0, mcnt} + {1'b0, off1} + 7'h01, full);
      end else begin
        p2cnt <= (p2cnt >= full - 6'h01) ? 6'h00 : p2cnt + 6'h01;
        p3cnt <= (p3cnt >= full - 6'h01) ? 6'h00 : p3cnt + 6'h01;
      end
      pll_phase2_output <= extra_phase_enable & (p2cnt < half);
      pll_phase3_output <= extra_phase_enable & (p3cnt < half);
    end
  end

  // feedback divider by m on main output rises
  assign main_rise = pll_main_output & ~main_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_prev <= 1'b0;
      fb_cnt <= 8'h00;
      fb_edge <= 1'b0;
    end else begin
      main_prev <= pll_main_output;
      fb_edge <= 1'b0;
      if (pll_power_down) begin
        fb_cnt <= 8'h00;
      end else if (main_rise) begin
        if ({1'b0, fb_cnt} + 9'h001 >= {1'b0, fb_div}) begin
          fb_cnt <= 8'h00;
          fb_edge <= 1'b1;
        end else begin
          fb_cnt <= fb_cnt + 8'h01;
        end
      end
    end
  end

  // lock detector: compares reference and feedback periods
  assign dlt = (fb_per > ref_meas) ? fb_per - ref_meas : ref_meas - fb_per;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_per <= 16'h0000;
      ref_meas <= 16'h0000;
      fb_per <= 16'h0000;
      lock_cnt <= 3'h0;
      pll_lock <= 1'b0;
    end else begin
      if (rise[pll_in_cur]) begin
        ref_meas <= ref_per;
        ref_per <= 16'h0001;
      end else if (ref_per != 16'hFFFF) begin
        ref_per <= ref_per + 16'h0001;
      end
      if (fb_edge)
        fb_per <= 16'h0001;
      else if (fb_per != 16'hFFFF)
        fb_per <= fb_per + 16'h0001;
      if (pll_power_down || pll_in_cur != pll_in_cfg ||
          !source_presence_status[pll_in_cur])
        lock_cnt <= 3'h0;
      else if (fb_edge && dlt > `CGUP_LOCK_TOL)
        lock_cnt <= 3'h0;
      else if (fb_edge && lock_cnt != `CGUP_LOCK_CONFIRM)
        lock_cnt <= lock_cnt + 3'h1;
      pll_lock <= ~pll_power_down &
                  (lock_cnt == `CGUP_LOCK_CONFIRM);
    end
  end

  // glitch-free output generators
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : outg
      reg [1:0] st;
      reg [2:0] cur;
      reg [2:0] hcnt;
      reg o;
      wire [2:0] want;
      wire is_pll;
      assign want = out_sel[3*g +: 3];
      assign is_pll = (cur >= `CGUP_SRC_PLL);
      assign base_clock_out[g] = o;

      // run, drain old source to low, hold low, start on new source
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st <= ST_RUN;
          cur <= `CGUP_SRC_RING;
          hcnt <= 3'h0;
          o <= 1'b0;
        end else begin
          case (st)
            ST_RUN: begin
              o <= lvl[cur] & ~stuck[cur];
              if (want != cur)
                st <= ST_DRAIN;
            end
            ST_DRAIN: begin
              if (!lvl[cur] || stuck[cur]) begin
                o <= 1'b0;
                cur <= want;
                hcnt <= 3'h0;
                st <= ST_HOLD;
              end else begin
                o <= lvl[cur];
              end
            end
            ST_HOLD: begin
              o <= 1'b0;
              if (hcnt != `CGUP_HOLD_CYC)
                hcnt <= hcnt + 3'h1;
              else if ((!is_pll || pll_lock) && !lvl[cur])
                st <= ST_RUN;
            end
            default: begin
              st <= ST_RUN;
              o <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate
endmodule

// ===== tb/cgup_clock_gen_props.sv
/*
  cgup_clock_gen_props.sv: port assertions for the clock generation block.
  assumes: bound into cgup_clock_gen, one pclk domain, presetn async low.
*/
`timescale 1ns/100ps

module cgup_clock_gen_props #(
  parameter NOUT = 2
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire crystal_input,
  input wire crystal_output,
  input wire [NOUT-1:0] base_clock_out,
  input wire pll_lock,
  input wire [6:0] src_activated,
  input wire [6:0] src_deactivated
);
  logic [13:0] hi_cnt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // consecutive high cycles of the first output clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt <= 14'h0000;
    else if (base_clock_out[0])
      hi_cnt <= hi_cnt + 14'h0001;
    else
      hi_cnt <= 14'h0000;
  end

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (psel && !penable && paddr > 8'h0C
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  event_pulse_a: assert property (|(src_activated | src_deactivated)
    |=> ((src_activated & $past(src_activated))
    | (src_deactivated & $past(src_deactivated))) == 7'h00)
    else $error("event longer than one cycle");
  event_excl_a: assert property ((src_activated & src_deactivated) == 7'h00)
    else $error("rise and fall event together");
  reset_quiet_a: assert property ($rose(presetn)
    |-> src_activated == 7'h00 && pll_lock == 1'b0)
    else $error("activity or lock right after reset");
  stuck_limit_a: assert property (hi_cnt < 14'h28A0)
    else $error("stuck high output not forced low");
  xtal_invert_a: assert property ($stable(crystal_input)[*5]
    |-> crystal_output == !crystal_input)
    else $error("crystal output not inverse of input");

  cover property (src_activated != 7'h00);
  cover property (src_deactivated != 7'h00);
  cover property ($rose(pll_lock));
endmodule

bind cgup_clock_gen cgup_clock_gen_props #(.NOUT(NOUT)) u_props (
  .pclk, .presetn, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
  .crystal_input, .crystal_output, .base_clock_out, .pll_lock,
  .src_activated, .src_deactivated);

// ===== tb/cgup_src_model.sv
/*
  cgup_src_model.sv: behavioural clock sources feeding the block.
  assumes: run and stuck come from the bench; a stopped source rests low,
  a stuck source rests high.
*/
`timescale 1ns/100ps

module cgup_src_model #(
  parameter int HALF_RING = 40,
  parameter int HALF_XTAL = 64,
  parameter int HALF_HOA = 28,
  parameter int HALF_HOB = 44
) (
  input wire logic [3:0] run,
  input wire logic [3:0] stuck,
  output logic ring_oscillator,
  output logic crystal_input,
  output logic handoff_base_clock_a,
  output logic handoff_base_clock_b
);
  logic [3:0] tog = 4'h0;

  // free running phases, each at its own rate
  always #HALF_RING tog[0] = ~tog[0];
  always #HALF_XTAL tog[1] = ~tog[1];
  always #HALF_HOA tog[2] = ~tog[2];
  always #HALF_HOB tog[3] = ~tog[3];

  // gate each phase with its run and stuck controls
  assign ring_oscillator = stuck[0] | (run[0] & tog[0]);
  assign crystal_input = stuck[1] | (run[1] & tog[1]);
  assign handoff_base_clock_a = stuck[2] | (run[2] & tog[2]);
  assign handoff_base_clock_b = stuck[3] | (run[3] & tog[3]);
endmodule

// ===== tb/tb_top.sv
/*
  tb_top.sv: self-checking bench for the clock generation block.
  assumes: sources from cgup_src_model; this module is the apb master.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tb_top;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d;
    logic [31:0] x; logic e;} cgup_row_t;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, plm, ph2, ph3, pll_lock, ring, xtal, hoa, hob;
  logic b0 = 0;
  logic [1:0] bco;
  logic [6:0] act, deact;
  logic [6:0] act_seen = 7'h00, deact_seen = 7'h00;
  logic [3:0] run = 4'h0, stuck = 4'h0;
  int err_count = 0, checks_done = 0, i, p, n, n2, n3, n4, wid = 0;
  int minw = 99;
  cgup_row_t rows [10] = '{
    '{8'h00, 1'b0, 32'h0, 32'h00000401, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h0C, 1'b1, 32'h007F007F, 32'h0, 1'b0},
    '{8'h0C, 1'b0, 32'h0, 32'h007F007F, 1'b0},
    '{8'h04, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h10, 1'b0, 32'h0, 32'h00000000, 1'b1},
    '{8'h10, 1'b1, 32'h00000001, 32'h0, 1'b1},
    '{8'h00, 1'b0, 32'h0, 32'h00000401, 1'b0}};

  initial forever #4 pclk = ~pclk;

  cgup_src_model SRC (.run(run), .stuck(stuck), .ring_oscillator(ring),
    .crystal_input(xtal), .handoff_base_clock_a(hoa),
    .handoff_base_clock_b(hob));

  cgup_clock_gen #(.NOUT(2)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_oscillator(ring), .crystal_input(xtal), .crystal_output(),
    .handoff_base_clock_a(hoa), .handoff_base_clock_b(hob),
    .base_clock_out(bco), .pll_main_output(plm), .pll_phase2_output(ph2),
    .pll_phase3_output(ph3), .pll_lock(pll_lock), .src_activated(act),
    .src_deactivated(deact));

  // latch events and track the shortest level of output 0
  always @(posedge pclk) begin
    if (presetn) begin
      act_seen <= act_seen | act;
      deact_seen <= deact_seen | deact;
      b0 <= bco[0];
      wid <= (bco[0] === b0) ? wid + 1 : 1;
      if (bco[0] !== b0 && wid < minw)
        minw <= wid;
    end
  end

  task automatic final_report();
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail_wait();
    err_count++;
    final_report();
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 50)
      fail_wait();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_lock();
    int k;
    for (k = 0; k < 4000 && pll_lock !== 1'b1; k++)
      @(posedge pclk);
    if (pll_lock !== 1'b1)
      fail_wait();
  endtask

  // rising edges of the pll outputs and output 1 over a window
  task automatic count_edges(input int cyc);
    logic a, b, c, d;
    a = plm;
    b = ph2;
    c = ph3;
    d = bco[1];
    n = 0;
    n2 = 0;
    n3 = 0;
    n4 = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (plm === 1'b1 && a === 1'b0)
        n++;
      if (ph2 === 1'b1 && b === 1'b0)
        n2++;
      if (ph3 === 1'b1 && c === 1'b0)
        n3++;
      if (bco[1] === 1'b1 && d === 1'b0)
        n4++;
      a = plm;
      b = ph2;
      c = ph3;
      d = bco[1];
    end
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[j]) begin
      apb(rows[j].a, rows[j].w, rows[j].d);
      if (!rows[j].w) `CHK("row read", rows[j].x, rd)
      `CHK("row error", rows[j].e, er)
    end
    run <= 4'hF;
    for (i = 0; i < 6000; i++) begin
      apb(8'h04, 1'b0, 32'h0);
      if (rd[1] === 1'b1)
        break;
    end
    if (i == 6000)
      fail_wait();
    `CHK("presence", 7'h0F, rd[14:8])
    `CHK("rise events", 7'h0F, act_seen)
    apb(8'h08, 1'b1, 32'h00000017);
    apb(8'h08, 1'b0, 32'h0);
    `CHK("invalid select", 32'h00000010, rd)
    apb(8'h08, 1'b1, 32'h00000011);
    repeat (300) @(posedge pclk);
    for (p = 0; p < 4; p++) begin
      apb(8'h00, 1'b1, 32'h00000430 | (p << 2));
      if (p == 0)
        wait_lock();
      if (p == 0) `CHK("lock", 1'b1, pll_lock)
      count_edges(512);
      `CHK("pll rate", 1'b1, ((n - (128 >> p)) inside {[-1:1]}))
      if (p == 0) `CHK("phase rate", 1'b1, ((n2 - n) inside {[-1:1]}))
      if (p == 0) `CHK("phase3 rate", 1'b1, ((n3 - n) inside {[-1:1]}))
      if (p == 0) `CHK("out1 rate", 1'b1, ((n4 - 73) inside {[-2:2]}))
    end
    apb(8'h00, 1'b1, 32'h00000432);
    count_edges(512);
    `CHK("bypass rate", 1'b1, ((n - 256) inside {[-1:1]}))
    apb(8'h00, 1'b1, 32'h00000431);
    repeat (4) @(posedge pclk);
    `CHK("lock in power down", 1'b0, pll_lock)
    count_edges(100);
    `CHK("stopped pll", 0, n)
    apb(8'h00, 1'b1, 32'h00000430);
    wait_lock();
    apb(8'h04, 1'b0, 32'h0);
    `CHK("relock status", 1'b1, rd[0])
    run[3] <= 1'b0;
    stuck[1] <= 1'b1;
    repeat (11000) @(posedge pclk);
    `CHK("fall event", 1'b1, deact_seen[3])
    `CHK("selected fall event", 1'b1, deact_seen[1])
    `CHK("forced low", 1'b0, bco[0])
    apb(8'h04, 1'b0, 32'h0);
    `CHK("absent sources", 2'b00, {rd[11], rd[9]})
    apb(8'h08, 1'b1, 32'h00000019);
    apb(8'h08, 1'b0, 32'h0);
    `CHK("absent select", 32'h00000011, rd)
    `CHK("no glitch", 1'b1, (minw >= 2 && minw < 20))
    final_report();
  end
endmodule
